// ---- logic/ccp_ctrl_map.svh ----
`ifndef CCP_CTRL_MAP_SVH
`define CCP_CTRL_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_SGC     12'h000
`define OFS_OEC     12'h004
`define OFS_STAT    12'h008

// ****************************************
// Reset values and writable masks
// ****************************************
`define SGC_RESET   16'h0000
`define OEC_RESET   16'h0000
`define SGC_WMASK   16'hd0ff
`define OEC_WMASK   16'hbfdf
`define OEC_SINGLE  16'h81df

// ****************************************
// Field positions
// ****************************************
`define SGC_RESTART 15
`define SGC_GATEM   14
`define SGC_FORCE   12
`define OEC_SYNC    15
`define OEC_OE_LO   8
`define OEC_GM_LO   6
`define OEC_AUX_LO  3
`define OEC_CS_LO   0
`define ST_ARM      10
`define ST_SHDN     4
`define ST_CDIS     2

`endif

// ---- logic/ccp_ctrl_pkg.sv ----
package ccp_ctrl_pkg;

	// Asynchronous source inputs
	typedef struct packed {
		logic [3:0] clc;
		logic [2:0] cmp;
		logic       fault_a;
		logic       fault_b;
		logic       fault_c;
		logic       fault_d;
		logic       cap_pin;
	} sources_t;

	// Output pin group
	typedef struct packed {
		logic [5:0] level;
		logic [5:0] oe;
		logic [5:0] own;
	} pins_t;

	typedef enum logic [1:0] {
		GM_LEVEL,
		GM_RISE,
		GM_FALL,
		GM_RSVD
	} gate_mode_t;

	typedef enum logic [1:0] {
		AUX_OFF,
		AUX_ROLL,
		AUX_MODE,
		AUX_EVENT
	} aux_sel_t;

	typedef enum {
		G_IDLE,
		G_ARMED
	} arm_state_t;

endpackage : ccp_ctrl_pkg

// ---- logic/ccp_shutdown_gating_output_ctrl.sv ----
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ccp_ctrl_map.svh"

// How it works
// (RULE1) Restart on: flag self-clears at period start once request gone
// (RULE2) Gate mode delays shutdown to next time-base event, else immediate
// (RULE3) Software force bit acts like a hardware source, same timing
// (RULE4) Eight enables, only enabled sources can cause shutdown or gating
// (RULE5) Enable bits map to comparators, faults, capture pin, logic cell
// (RULE6) Unimplemented bits ignore writes and read zero
// (RULE7) Output enable sync defers enable changes to next time-base event
// (RULE8) Each enable hands its pin to the module, zero releases it
// (RULE9) Single-output instance keeps only the output A enable
// (RULE10) Gating mode 10: armed falling edge sets capture disable
// (RULE11) Gating mode 01: armed rising edge clears disable; 11 reserved
// (RULE12) Gating mode 00: capture disable follows inverted source level
// (RULE13) Aux select: off, rollover, mode signal, capture/compare event
// (RULE14) Capture source: pin, comparators 1 to 3, logic cells 1 to 4
// (RULE15) Shutdown flag is one while outputs sit in shutdown state
// (RULE16) Capture disable flag blocks capture events
// (RULE17) Gate arm write-one arms one-shot gating, reads zero
// (RULE18) Shutdown drives groups active, inactive or tri-stated
// (RULE19) Request is OR of enabled sources and software force
// (RULE20) All asynchronous source inputs pass a two-stage synchroniser
module ccp_shutdown_gating_output_ctrl
	import ccp_ctrl_pkg::*;
#(
	parameter bit MULTI_OUT = 1'b1
) (
	// Clock, reset, enable
	input  wire logic        REF_CLK,
	input  wire logic        NRST,
	input  wire logic        CE,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Sources and module events
	input  sources_t         SRC,
	input  wire logic        TB_EVENT,
	input  wire logic        CAP_EVENT_IN,
	input  wire logic        MODE_SIGNAL,
	input  wire logic        TIMER_MODE,
	input  wire logic [5:0]  PWM_IN,
	input  wire logic [1:0]  SHDN_STATE_ACE,
	input  wire logic [1:0]  SHDN_STATE_BDF,
	// Outputs
	output pins_t            PINS,
	output logic             SHDN_ACTIVE,
	output logic             CAP_DISABLED,
	output logic             CAP_SIGNAL,
	output logic             CAP_EVENT_OUT,
	output logic             AUX_OUT
);

	// ****************************************
	// Register bus
	// ****************************************
	logic [15:0] sgc_q;
	logic [15:0] oec_q;
	logic [31:0] rdata_q;
	logic        shdn_q;
	logic        cdis_q;
	logic        setup;
	logic        access;
	logic        wr;
	logic        hit;
	logic [15:0] oec_wmask;
	logic [15:0] stat_rd;

	assign setup  = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE & CE;
	assign wr     = access & PWRITE;
	assign PREADY = CE;
	assign PRDATA = rdata_q;
	assign hit    = (PADDR == `OFS_SGC) || (PADDR == `OFS_OEC)
		|| (PADDR == `OFS_STAT);
	assign PSLVERR = access & ~hit;
	assign oec_wmask = MULTI_OUT ? `OEC_WMASK : `OEC_SINGLE; // [RULE9]

	// Arm bit always reads zero
	assign stat_rd = {11'h000, shdn_q, 1'b0, cdis_q, 2'h0}; // [RULE17]

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sgc_q <= `SGC_RESET;
			oec_q <= `OEC_RESET;
		end else if (wr && PADDR == `OFS_SGC) begin
			sgc_q <= PWDATA[15:0] & `SGC_WMASK; // [RULE6]
		end else if (wr && PADDR == `OFS_OEC) begin
			oec_q <= PWDATA[15:0] & oec_wmask; // [RULE6]
		end
	end

	// Data captured in setup keeps read data on a flop, no wait state
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rdata_q <= 32'h0000_0000;
		end else if (CE && setup) begin
			if (PADDR == `OFS_SGC) begin
				rdata_q <= {16'h0000, sgc_q};
			end else if (PADDR == `OFS_OEC) begin
				rdata_q <= {16'h0000, oec_q};
			end else if (PADDR == `OFS_STAT) begin
				rdata_q <= {16'h0000, stat_rd};
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	logic st_wr;
	logic arm_wr;
	logic shdn_clr_wr;

	assign st_wr       = wr && PADDR == `OFS_STAT;
	assign arm_wr      = st_wr & PWDATA[`ST_ARM]; // [RULE17]
	assign shdn_clr_wr = st_wr & PWDATA[`ST_SHDN];

	// ****************************************
	// Source synchroniser
	// ****************************************
	sources_t sync1_q;
	sources_t src_s;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sync1_q <= '0;
			src_s   <= '0;
		end else if (CE) begin
			sync1_q <= SRC; // [RULE20]
			src_s   <= sync1_q; // [RULE20]
		end
	end

	// ****************************************
	// Shutdown request and flag
	// ****************************************
	logic [7:0] src_vec;
	logic       req;
	logic       shdn_set;
	logic       shdn_clr;

	assign src_vec = {src_s.fault_b, src_s.fault_a, src_s.clc[0],
		src_s.cap_pin, src_s.fault_d, src_s.fault_c,
		src_s.cmp[1], src_s.cmp[0]}; // [RULE5]
	assign req = (|(src_vec & sgc_q[7:0])) // [RULE4]
		| sgc_q[`SGC_FORCE]; // [RULE19] [RULE3]
	assign shdn_set = req & (~sgc_q[`SGC_GATEM] | TB_EVENT); // [RULE2]
	assign shdn_clr = shdn_clr_wr
		| (sgc_q[`SGC_RESTART] & TB_EVENT & ~req); // [RULE1]

	// Set wins over a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			shdn_q <= 1'b0;
		end else if (CE) begin
			if (shdn_set) begin
				shdn_q <= 1'b1; // [RULE15]
			end else if (shdn_clr) begin
				shdn_q <= 1'b0; // [RULE1]
			end
		end
	end

	assign SHDN_ACTIVE = shdn_q;

	// ****************************************
	// Output enables and pins
	// ****************************************
	logic [5:0] oe_q;
	logic [5:0] state_lo;
	logic [5:0] state_hi;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			oe_q <= 6'h00;
		end else if (CE && (!oec_q[`OEC_SYNC] || TB_EVENT)) begin
			oe_q <= oec_q[`OEC_OE_LO +: 6]; // [RULE7]
		end
	end

	// Groups: A,C,E in even bits, B,D,F in odd bits
	assign state_hi = {SHDN_STATE_BDF[1], SHDN_STATE_ACE[1],
		SHDN_STATE_BDF[1], SHDN_STATE_ACE[1],
		SHDN_STATE_BDF[1], SHDN_STATE_ACE[1]};
	assign state_lo = {SHDN_STATE_BDF[0], SHDN_STATE_ACE[0],
		SHDN_STATE_BDF[0], SHDN_STATE_ACE[0],
		SHDN_STATE_BDF[0], SHDN_STATE_ACE[0]};

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PINS <= '0;
		end else if (CE) begin
			PINS.own <= oe_q; // [RULE8]
			if (shdn_q) begin
				PINS.level <= state_lo & oe_q; // [RULE18]
				PINS.oe    <= state_hi & oe_q; // [RULE18]
			end else begin
				PINS.level <= PWM_IN & oe_q; // [RULE8]
				PINS.oe    <= oe_q;
			end
		end
	end

	// ****************************************
	// Capture gating
	// ****************************************
	gate_mode_t gmode;
	arm_state_t arm_q;
	logic       gate_prev_q;
	logic       g_rise;
	logic       g_fall;

	assign gmode  = gate_mode_t'(oec_q[`OEC_GM_LO +: 2]);
	assign g_rise = req & ~gate_prev_q;
	assign g_fall = ~req & gate_prev_q;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			gate_prev_q <= 1'b0;
		end else if (CE) begin
			gate_prev_q <= req;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			arm_q  <= G_IDLE;
			cdis_q <= 1'b0;
		end else if (CE) begin
			case (arm_q)
				G_IDLE: begin
					if (arm_wr) begin
						arm_q <= G_ARMED; // [RULE17]
					end
				end
				G_ARMED: begin
					if (gmode == GM_FALL && g_fall) begin
						arm_q  <= G_IDLE;
						cdis_q <= 1'b1; // [RULE10]
					end else if (gmode == GM_RISE && g_rise) begin
						arm_q  <= G_IDLE;
						cdis_q <= 1'b0; // [RULE11]
					end
				end
				default: arm_q <= G_IDLE;
			endcase
			// Level mode ignores arming; reserved code holds
			if (gmode == GM_LEVEL) begin
				cdis_q <= ~req; // [RULE12]
			end
		end
	end

	assign CAP_DISABLED = cdis_q;

	// ****************************************
	// Capture source and aux output
	// ****************************************
	logic     cap_mux;
	aux_sel_t aux_sel;
	logic     aux_d;

	always_comb begin
		cap_mux = src_s.cap_pin;
		if (oec_q[2]) begin
			cap_mux = src_s.clc[oec_q[1:0]]; // [RULE14]
		end else if (oec_q[1:0] != 2'h0) begin
			cap_mux = src_s.cmp[oec_q[1:0] - 2'h1]; // [RULE14]
		end
	end

	assign aux_sel = aux_sel_t'(oec_q[`OEC_AUX_LO +: 2]);

	always_comb begin
		case (aux_sel)
			AUX_ROLL:  aux_d = TB_EVENT; // [RULE13]
			AUX_MODE:  aux_d = MODE_SIGNAL; // [RULE13]
			AUX_EVENT: aux_d = CAP_EVENT_IN & ~TIMER_MODE; // [RULE13]
			default:   aux_d = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			CAP_SIGNAL    <= 1'b0;
			CAP_EVENT_OUT <= 1'b0;
			AUX_OUT       <= 1'b0;
		end else if (CE) begin
			CAP_SIGNAL    <= cap_mux;
			CAP_EVENT_OUT <= CAP_EVENT_IN & ~cdis_q; // [RULE16]
			AUX_OUT       <= aux_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	a_shdn_immediate: assert property ( // [RULE2]
		CE && req && !sgc_q[`SGC_GATEM] |=> shdn_q)
		else $error("shutdown not immediate");
	a_shdn_gated: assert property ( // [RULE2]
		$rose(shdn_q) |-> $past(!sgc_q[`SGC_GATEM] || TB_EVENT))
		else $error("gated shutdown off time-base event");
	a_shdn_release: assert property ( // [RULE1]
		$fell(shdn_q) |-> $past(shdn_clr_wr
		|| (sgc_q[`SGC_RESTART] && TB_EVENT && !req)))
		else $error("shutdown flag cleared without cause");
	a_force_shdn: assert property ( // [RULE3]
		CE && sgc_q[`SGC_FORCE] && !sgc_q[`SGC_GATEM] |=> shdn_q)
		else $error("software force ignored");
	a_src_enable: assert property ( // [RULE4]
		sgc_q[7:0] == 8'h00 && !sgc_q[`SGC_FORCE] |-> !req)
		else $error("disabled source raised request");
	a_oe_sync: assert property ( // [RULE7]
		$changed(oe_q) |-> $past(!oec_q[`OEC_SYNC] || TB_EVENT))
		else $error("output enable changed off sync point");
	a_single_out: assert property ( // [RULE9]
		!MULTI_OUT |-> oe_q[5:1] == 5'h00)
		else $error("extra enable in single-output instance");
	a_level_gate: assert property ( // [RULE12]
		CE && gmode == GM_LEVEL |=> cdis_q == !$past(req))
		else $error("level gating mismatch");
	a_cap_block: assert property ( // [RULE16]
		CE && cdis_q |=> !CAP_EVENT_OUT)
		else $error("capture passed while disabled");
	a_arm_read: assert property ( // [RULE17]
		CE && setup && PADDR == `OFS_STAT |=> !PRDATA[`ST_ARM])
		else $error("arm bit read nonzero");

endmodule : ccp_shutdown_gating_output_ctrl

// ---- testbench/ccp_src_model.sv ----
`timescale 1ns/1ps
module ccp_src_model
	import ccp_ctrl_pkg::*;
(
	// Bench control
	input  wire logic [2:0] PICK,
	input  wire logic       ON,
	input  wire logic [3:0] SPARE,
	// Source levels
	output sources_t        SRC
);
	// Only one shutdown enable map source high at a time, so a wrong map shows at once
	always_comb begin
		SRC = '0;
		// Capture-only sources, outside the shutdown enable map
		SRC.cmp[2]   = SPARE[0];
		SRC.clc[3:1] = SPARE[3:1];
		case (PICK)
			3'h0: SRC.cmp[0] = ON;
			3'h1: SRC.cmp[1] = ON;
			3'h2: SRC.fault_c = ON;
			3'h3: SRC.fault_d = ON;
			3'h4: SRC.cap_pin = ON;
			3'h5: SRC.clc[0] = ON;
			3'h6: SRC.fault_a = ON;
			default: SRC.fault_b = ON;
		endcase
	end
endmodule : ccp_src_model

// ---- testbench/ccp_shutdown_gating_output_ctrl_test.sv ----
`timescale 1ns/1ps
`include "ccp_ctrl_map.svh"
module ccp_shutdown_gating_output_ctrl_test import ccp_ctrl_pkg::*;;
	logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0;
	logic [11:0] padr = '0;
	logic [31:0] pwd = '0, prd, rd;
	logic        prdy, perr, er, cev, shdn, cdis;
	logic        tbe = 0, cin = 0, on = 0;
	logic [1:0]  ace = 2'h3, bdf = 2'h2;
	logic [2:0]  pick = '0;
	logic        mode = 0, tmr = 0, capsig, aux;
	logic [5:0]  pwm = '0;
	logic [3:0]  spare = '0;
	logic [31:0] prd1;
	pins_t       pins1;
	sources_t    src;
	pins_t       pins;
	int          n_mismatch = 0, num_checks = 0, cycles = 0;

	always #2.5 clk = ~clk;

	ccp_src_model u_src (
		.PICK(pick), .ON(on), .SPARE(spare), .SRC(src)
	);

	ccp_shutdown_gating_output_ctrl u_dut (
		.REF_CLK(clk), .NRST(nrst), .CE(1'b1),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.SRC(src), .TB_EVENT(tbe), .CAP_EVENT_IN(cin),
		.MODE_SIGNAL(mode), .TIMER_MODE(tmr), .PWM_IN(pwm),
		.SHDN_STATE_ACE(ace), .SHDN_STATE_BDF(bdf), .PINS(pins),
		.SHDN_ACTIVE(shdn), .CAP_DISABLED(cdis), .CAP_SIGNAL(capsig),
		.CAP_EVENT_OUT(cev), .AUX_OUT(aux)
	);

	// Single-output instance on the same bus, only its reads and pin ownership are watched
	ccp_shutdown_gating_output_ctrl #(.MULTI_OUT(1'b0)) u_single (
		.REF_CLK(clk), .NRST(nrst), .CE(1'b1),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
		.PWDATA(pwd), .PRDATA(prd1), .PREADY(), .PSLVERR(),
		.SRC(src), .TB_EVENT(tbe), .CAP_EVENT_IN(cin),
		.MODE_SIGNAL(mode), .TIMER_MODE(tmr), .PWM_IN(pwm),
		.SHDN_STATE_ACE(ace), .SHDN_STATE_BDF(bdf), .PINS(pins1),
		.SHDN_ACTIVE(), .CAP_DISABLED(), .CAP_SIGNAL(),
		.CAP_EVENT_OUT(), .AUX_OUT()
	);

	// ****************************************
	// Tasks
	// ****************************************
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check

	// Request held until pready is seen high at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task settle;
		repeat (5) @(posedge clk);
	endtask : settle

	task tick;
		@(posedge clk);
		tbe <= 1'b1;
		@(posedge clk);
		tbe <= 1'b0;
		settle;
	endtask : tick

	task capev(input logic exp);
		@(posedge clk);
		cin <= 1'b1;
		@(posedge clk);
		cin <= 1'b0;
		#1 check(cev, exp);
	endtask : capev

	// One-cycle time-base and capture pulses, aux output seen a cycle later
	task pulse(input logic t, input logic c, input logic exp);
		@(posedge clk);
		tbe <= t;
		cin <= c;
		@(posedge clk);
		tbe <= 1'b0;
		cin <= 1'b0;
		#1 check(aux, exp);
	endtask : pulse

	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			n_mismatch++;
			final_report;
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb(0, `OFS_SGC, 0); check(rd, 0);
		apb(1, `OFS_SGC, '1); apb(0, `OFS_SGC, 0); check(rd, 'hd0ff);
		apb(1, `OFS_OEC, '1); apb(0, `OFS_OEC, 0); check(rd, 'hbfdf);
		check(prd1, 'h81df);
		apb(0, 12'h00c, 0); check(rd, 0);
		check(er, 1);
		apb(1, `OFS_STAT, 'h400); apb(0, `OFS_STAT, 0); check(rd[10], 0);
		$display("test registers done");
		apb(1, `OFS_SGC, 0); apb(1, `OFS_STAT, 'h10);
		apb(1, `OFS_OEC, 'h100); settle; check(pins.own, 1);
		apb(1, `OFS_OEC, 'h8300); settle; check(pins.own, 1);
		tick; check(pins.own, 3);
		check(pins1.own, 1);
		$display("test output enables done");
		for (int i = 0; i < 8; i++) begin
			pick <= 3'(i);
			on <= 1'b1;
			apb(1, `OFS_SGC, 1 << ((i + 1) % 8)); settle; check(shdn, 0);
			apb(1, `OFS_SGC, 1 << i); settle; check(shdn, 1);
			check({pins.oe[0], pins.level[0]}, 2'h3);
			check({pins.oe[1], pins.level[1]}, 2'h2);
			on <= 1'b0;
			settle; check(shdn, 1);
			apb(1, `OFS_STAT, 'h10); settle; check(shdn, 0);
		end
		$display("test sources done");
		apb(1, `OFS_SGC, 'h5000); settle; check(shdn, 0);
		tick; check(shdn, 1);
		apb(1, `OFS_SGC, 'h8000); settle; check(shdn, 1);
		tick; check(shdn, 0);
		$display("test gate mode done");
		apb(1, `OFS_OEC, 0); settle; check(cdis, 1);
		apb(1, `OFS_SGC, 'h1000); settle; check(cdis, 0);
		apb(1, `OFS_OEC, 'h80); apb(1, `OFS_STAT, 'h400);
		apb(1, `OFS_SGC, 0); settle; check(cdis, 1);
		capev(1'b0);
		apb(1, `OFS_OEC, 'h40); apb(1, `OFS_STAT, 'h400);
		apb(1, `OFS_SGC, 'h1000); settle; check(cdis, 0);
		capev(1'b1);
		apb(1, `OFS_SGC, 0); settle; check(cdis, 0);
		$display("test capture gating done");
		apb(1, `OFS_STAT, 'h10);
		// Only the source behind select s is high, its neighbour is low
		for (int s = 0; s < 8; s++) begin
			pick  <= (s == 0) ? 3'h4 : (s == 4) ? 3'h5 : 3'(s - 1);
			on    <= (s == 0) || (s == 1) || (s == 2) || (s == 4);
			spare <= (s == 3) ? 4'h1 : (s > 4) ? 4'(1 << (s - 4)) : 4'h0;
			apb(1, `OFS_OEC, s);
			settle;
			check(capsig, 1);
			apb(1, `OFS_OEC, (s + 1) % 8);
			settle;
			check(capsig, 0);
		end
		on    <= 1'b0;
		spare <= 4'h0;
		$display("test capture source done");
		apb(1, `OFS_OEC, 'h00);
		pulse(1'b1, 1'b1, 1'b0);
		apb(1, `OFS_OEC, 'h08);
		pulse(1'b1, 1'b0, 1'b1);
		pulse(1'b0, 1'b1, 1'b0);
		apb(1, `OFS_OEC, 'h10);
		mode <= 1'b1;
		settle;
		check(aux, 1);
		mode <= 1'b0;
		settle;
		check(aux, 0);
		apb(1, `OFS_OEC, 'h18);
		pulse(1'b0, 1'b1, 1'b1);
		pulse(1'b1, 1'b0, 1'b0);
		@(posedge clk) tmr <= 1'b1;
		pulse(1'b0, 1'b1, 1'b0);
		@(posedge clk) tmr <= 1'b0;
		$display("test aux output done");
		apb(1, `OFS_OEC, 'h500);
		pwm <= 6'h3f;
		settle;
		check(pins.level, 'h05);
		check(pins.oe, 'h05);
		apb(1, `OFS_SGC, 'h1000);
		pwm <= 6'h00;
		settle;
		check(pins.level, 'h05);
		check(pins.oe, 'h05);
		ace <= 2'h1;
		settle;
		check(pins.oe, 'h00);
		$display("test pin steering done");
		final_report;
	end
endmodule : ccp_shutdown_gating_output_ctrl_test
